/* rtl/fma_params.svh */
// Purpose: Constants for the frame memory arbiter
// Assumes: Included by bare name from the design file
// Notes: Offsets are APB byte addresses
`ifndef FMA_PARAMS_SVH
`define FMA_PARAMS_SVH
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define FMA_CTRL_OFS 12'h000
`define FMA_STAT_OFS 12'h004
// Control fields
`define FMA_CTRL_FILL_BIT 0
`define FMA_CTRL_BLK_LSB 1
`define FMA_CTRL_ROMEN_BIT 4
`define FMA_CTRL_RESET 32'h0000_0001
// Status fields
`define FMA_STAT_LINE_LSB 0
`define FMA_STAT_HPOS_LSB 16
`define FMA_STAT_OWN_BIT 24
`define FMA_STAT_PEND_BIT 25
// ----------------------------------------------------------------
// Raster timing, in byte times and lines
// ----------------------------------------------------------------
`define FMA_SYNC_BYTES 6'h03
`define FMA_LEFT_BYTES 6'h05
`define FMA_DATA_BYTES 6'h20
`define FMA_RIGHT_BYTES 6'h06
`define FMA_LINE_BYTES 6'h2e
`define FMA_FRAME_LINES 9'h106
`define FMA_VBLANK_LINE 9'h100
`define FMA_DOT_DIV 1'h1
`endif

/* rtl/fma_pkg.sv */
// Purpose: Types for the frame memory arbiter
// Assumes: Nothing
// Notes: Sequencer states are one-hot
package fma_pkg;
  // Memory cycle sequencer stages
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_CE1 = 4'h2,
    SEQ_CE2 = 4'h4,
    SEQ_CE3 = 4'h8
  } fma_seq_type;
endpackage : fma_pkg

/* rtl/fma_top.sv */
// Purpose: Shared frame memory, raster timing and host/video arbiter
// Assumes: pclk stands in for the crystal clock; dot clock is an enable
// Notes: Control and status reach software over APB
//
// How it works
// - 8192 byte frame memory as host RAM
// - Even and odd banks, never both enabled
// - Display fetches alone keep memory refreshed
// - Store complemented, complement again on read
// - Write drivers on only during write cycles
// - Fill low forces all read values ones
// - Address from video counter or host
// - Line is 3+5+32+6 = 46 byte times
// - Frame is 262 lines at 60 Hz
// - Dot clock is crystal divided by two
// - Line counter, byte counter one ahead
// - Low three counter stages select pixel
// - Shift sequencer: enable, then two strobes
// - Video cycle two dots, host three
// - Decode block, request, no refresh, ROM
// - Board select gates host, idle high
// - Select fall sets pending, owner swaps idle
// - Hold request while host owns memory
// - Stage three clears pending, then revert
// - Fetch request at bit seven, stage two clears
// - Pending request starts a memory cycle
// - Stage three captures host data, drive while selected
`timescale 1ns/1ps
`include "fma_params.svh"
module fma_top (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host memory bus
  input wire logic [15:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic mem_request,
  input wire logic refresh_n,
  input wire logic rom_select,
  input wire logic board_select,
  output logic [7:0] host_rdata,
  output logic host_rdata_oe,
  output logic hold_request,
  output logic host_select_n,
  // Memory side strobes
  output logic even_bank_enable,
  output logic odd_bank_enable,
  output logic write_buffer_enable,
  output logic video_owns_memory,
  // Video out
  output logic video_pixel,
  output logic hsync,
  output logic vsync
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] even_mem [4096]; // Even byte bank, stored inverted
  logic [7:0] odd_mem [4096]; // Odd byte bank, stored inverted
  logic [31:0] ctrl_q, ctrl_d; // Control register
  logic [31:0] prdata_q, prdata_d; // APB read data
  logic pready_q, pready_d; // APB ready
  logic pslverr_q, pslverr_d; // APB error
  logic dot_ph_q, dot_ph_d; // Crystal divider phase
  logic [2:0] bit_q, bit_d; // Pixel within byte
  logic [5:0] hpos_q, hpos_d; // Byte time within line
  logic [8:0] line_q, line_d; // Scan line
  logic [7:0] shift_q, shift_d; // Pixel shifter
  logic [7:0] vbyte_q, vbyte_d; // Fetched display byte
  logic [12:0] vaddr_q, vaddr_d; // Display fetch address
  fma_pkg::fma_seq_type seq_q, seq_d; // Memory cycle sequencer
  logic cyc_host_q, cyc_host_d; // Current cycle is a host cycle
  logic own_q, own_d; // Video owns memory
  logic pend_q, pend_d; // Host pending
  logic fetch_q, fetch_d; // Display fetch request
  logic done_q, done_d; // Host cycle finished
  logic sel_n_q, sel_n_d; // Host select, active low
  logic [7:0] hdata_q, hdata_d; // Host read holding register
  logic hoe_q, hoe_d; // Host data drive
  logic hold_q, hold_d; // Hold toward processor
  logic even_q, even_d; // Even bank enable
  logic odd_q, odd_d; // Odd bank enable
  logic wbe_q, wbe_d; // Write buffer enable
  logic hs_q, hs_d; // Horizontal sync
  logic vs_q, vs_d; // Vertical sync
  // Combinational helpers
  logic dot_tick; // One pclk in two
  logic fill_n; // Fill control, low forces ones
  logic [12:0] maddr; // Selected memory address
  logic [7:0] rdata; // True read data after buffers
  logic mem_we; // Memory write strobe
  logic [5:0] fbyte; // Byte counter at fetch time

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Decode in setup cycle, answer in access cycle
  always_comb begin
    ctrl_d = ctrl_q;
    prdata_d = 32'h0000_0000;
    pready_d = psel & ~penable;
    pslverr_d = 1'b0;
    // Write lands only at the edge that ends the access phase
    if (psel && penable && pready_q && pwrite && paddr == `FMA_CTRL_OFS) begin
      ctrl_d = {27'h000_0000, pwdata[4:0]};
    end
    if (psel && !penable) begin
      case (paddr)
        `FMA_CTRL_OFS: begin
          // Writable control word
          prdata_d = ctrl_q;
        end
        `FMA_STAT_OFS: begin
          // Live raster and ownership status
          prdata_d[`FMA_STAT_LINE_LSB +: 9] = line_q;
          prdata_d[`FMA_STAT_HPOS_LSB +: 6] = hpos_q;
          prdata_d[`FMA_STAT_OWN_BIT] = own_q;
          prdata_d[`FMA_STAT_PEND_BIT] = pend_q;
        end
        default: begin
          // Unmapped address
          pslverr_d = 1'b1;
        end
      endcase
    end
  end

  // APB registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `FMA_CTRL_RESET;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // Raster timing
  // ----------------------------------------------------------------
  assign dot_tick = dot_ph_q;
  assign fbyte = hpos_q - 6'h06;

  // Dot divider and bit, byte and line counters
  always_comb begin
    dot_ph_d = dot_ph_q ^ `FMA_DOT_DIV;
    bit_d = bit_q;
    hpos_d = hpos_q;
    line_d = line_q;
    shift_d = shift_q;
    if (dot_tick) begin
      bit_d = bit_q + 3'h1;
      shift_d = {shift_q[6:0], 1'b0};
      if (bit_q == 3'h7) begin
        // Next byte: load only inside data area
        if (hpos_q >= 6'h07 && hpos_q < 6'h27) begin
          shift_d = vbyte_q;
        end else begin
          shift_d = 8'h00;
        end
        if (hpos_q == `FMA_LINE_BYTES - 6'h01) begin
          hpos_d = 6'h00;
          if (line_q == `FMA_FRAME_LINES - 9'h001) begin
            line_d = 9'h000;
          end else begin
            line_d = line_q + 9'h001;
          end
        end else begin
          hpos_d = hpos_q + 6'h01;
        end
      end
    end
    hs_d = hpos_d < `FMA_SYNC_BYTES;
    vs_d = line_d >= `FMA_VBLANK_LINE;
  end

  // Raster registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dot_ph_q <= 1'b0;
      bit_q <= 3'h0;
      hpos_q <= 6'h00;
      line_q <= 9'h000;
      shift_q <= 8'h00;
      hs_q <= 1'b1;
      vs_q <= 1'b0;
    end else begin
      dot_ph_q <= dot_ph_d;
      bit_q <= bit_d;
      hpos_q <= hpos_d;
      line_q <= line_d;
      shift_q <= shift_d;
      hs_q <= hs_d;
      vs_q <= vs_d;
    end
  end

  // ----------------------------------------------------------------
  // Memory and data paths
  // ----------------------------------------------------------------
  assign fill_n = ctrl_q[`FMA_CTRL_FILL_BIT];
  // Video address while video owns, host address otherwise
  assign maddr = own_q ? vaddr_q : host_addr[12:0];
  // Read buffers re-invert, or force ones when filling
  always_comb begin
    if (maddr[0]) begin
      rdata = ~odd_mem[maddr[12:1]];
    end else begin
      rdata = ~even_mem[maddr[12:1]];
    end
    if (!fill_n) begin
      rdata = 8'hff;
    end
  end
  // Host write lands at stage two of a host cycle
  assign mem_we = dot_tick & cyc_host_q & host_wr & (seq_q == fma_pkg::SEQ_CE2);

  // Bank storage, no reset on memory cells
  always_ff @(posedge pclk) begin
    if (mem_we && !maddr[0]) begin
      even_mem[maddr[12:1]] <= ~host_wdata;
    end
    if (mem_we && maddr[0]) begin
      odd_mem[maddr[12:1]] <= ~host_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Host decode, arbiter and sequencer
  // ----------------------------------------------------------------
  always_comb begin
    // Block match, request, no refresh, board selected, no ROM overlap
    sel_n_d = ~((host_addr[15:13] == ctrl_q[`FMA_CTRL_BLK_LSB +: 3])
      & mem_request & refresh_n & board_select
      & ~(ctrl_q[`FMA_CTRL_ROMEN_BIT] & rom_select));
    seq_d = seq_q;
    cyc_host_d = cyc_host_q;
    own_d = own_q;
    done_d = done_q;
    vaddr_d = vaddr_q;
    vbyte_d = vbyte_q;
    hdata_d = hdata_q;
    pend_d = pend_q;
    fetch_d = fetch_q;
    // Stage three clears pending
    if (dot_tick && seq_q == fma_pkg::SEQ_CE3 && !own_q) begin
      pend_d = 1'b0;
    end
    // Select falling edge sets pending, set wins
    if (sel_n_q && !sel_n_d) begin
      pend_d = 1'b1;
    end
    // Stage two clears fetch request while video owns
    if (dot_tick && seq_q == fma_pkg::SEQ_CE2 && own_q) begin
      fetch_d = 1'b0;
    end
    // First crystal edge after bit counter reads seven
    if (bit_q == 3'h7 && !dot_ph_q) begin
      fetch_d = 1'b1;
      vaddr_d = {line_q[7:0], fbyte[4:0]};
    end
    if (dot_tick) begin
      case (seq_q)
        fma_pkg::SEQ_IDLE: begin
          if (own_q && pend_q) begin
            own_d = 1'b0;
          end else if (!own_q && done_q) begin
            own_d = 1'b1;
            done_d = 1'b0;
          end else if (!own_q) begin
            seq_d = fma_pkg::SEQ_CE1;
            cyc_host_d = 1'b1;
          end else if (fetch_q) begin
            seq_d = fma_pkg::SEQ_CE1;
            cyc_host_d = 1'b0;
          end
        end
        fma_pkg::SEQ_CE1: begin
          seq_d = fma_pkg::SEQ_CE2;
        end
        fma_pkg::SEQ_CE2: begin
          if (cyc_host_q) begin
            seq_d = fma_pkg::SEQ_CE3;
          end else begin
            seq_d = fma_pkg::SEQ_IDLE;
            vbyte_d = rdata;
          end
        end
        fma_pkg::SEQ_CE3: begin
          seq_d = fma_pkg::SEQ_IDLE;
          done_d = 1'b1;
          if (!own_q) begin
            hdata_d = rdata;
          end
        end
        default: begin
          seq_d = fma_pkg::SEQ_IDLE;
        end
      endcase
    end
    // Output strobes follow next state
    even_d = (seq_d != fma_pkg::SEQ_IDLE) & ~maddr[0];
    odd_d = (seq_d != fma_pkg::SEQ_IDLE) & maddr[0];
    wbe_d = (seq_d != fma_pkg::SEQ_IDLE) & cyc_host_d & host_wr & ~own_q;
    hold_d = ~own_d;
    hoe_d = ~sel_n_d;
  end

  // Arbiter and sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_q <= fma_pkg::SEQ_IDLE;
      cyc_host_q <= 1'b0;
      own_q <= 1'b1;
      done_q <= 1'b0;
      pend_q <= 1'b0;
      fetch_q <= 1'b0;
      sel_n_q <= 1'b1;
      vaddr_q <= 13'h0000;
      vbyte_q <= 8'h00;
      hdata_q <= 8'h00;
      even_q <= 1'b0;
      odd_q <= 1'b0;
      wbe_q <= 1'b0;
      hold_q <= 1'b0;
      hoe_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      cyc_host_q <= cyc_host_d;
      own_q <= own_d;
      done_q <= done_d;
      pend_q <= pend_d;
      fetch_q <= fetch_d;
      sel_n_q <= sel_n_d;
      vaddr_q <= vaddr_d;
      vbyte_q <= vbyte_d;
      hdata_q <= hdata_d;
      even_q <= even_d;
      odd_q <= odd_d;
      wbe_q <= wbe_d;
      hold_q <= hold_d;
      hoe_q <= hoe_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign host_rdata = hdata_q;
  assign host_rdata_oe = hoe_q;
  assign hold_request = hold_q;
  assign host_select_n = sel_n_q;
  assign even_bank_enable = even_q;
  assign odd_bank_enable = odd_q;
  assign write_buffer_enable = wbe_q;
  assign video_owns_memory = own_q;
  assign video_pixel = shift_q[7];
  assign hsync = hs_q;
  assign vsync = vs_q;
endmodule : fma_top

/* test/fma_props.sv */
// Purpose: Port checks for fma_top
// Assumes: One clock, async active-low reset
// Notes: Bound to every fma_top instance
`timescale 1ns/1ps
module fma_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Host side
  input wire logic host_wr,
  input wire logic mem_request,
  input wire logic refresh_n,
  input wire logic board_select,
  input wire logic host_select_n,
  input wire logic host_rdata_oe,
  input wire logic hold_request,
  // Memory and video
  input wire logic even_bank_enable,
  input wire logic odd_bank_enable,
  input wire logic write_buffer_enable,
  input wire logic video_owns_memory,
  input wire logic hsync
);
  // ------------------------------------------------------------
  // Line timer helpers
  // ------------------------------------------------------------
  logic ce_any; // Either bank running
  logic [9:0] gap_q; // Cycles since last sync rise
  logic [9:0] gap_d;
  logic seen_q; // One rise already seen
  logic seen_d;
  logic hs_q; // Sync one cycle back
  assign ce_any = even_bank_enable | odd_bank_enable;
  // Restart the count at each sync rise
  always_comb begin
    gap_d = gap_q + 10'h001;
    seen_d = seen_q;
    if (hsync && !hs_q) begin
      gap_d = 10'h001;
      seen_d = 1'b1;
    end
  end
  // Register the timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 10'h000;
      seen_q <= 1'b0;
      hs_q <= 1'b1;
    end else begin
      gap_q <= gap_d;
      seen_q <= seen_d;
      hs_q <= hsync;
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_banks_apart: assert property (!(even_bank_enable && odd_bank_enable))
    else $error("both banks enabled");
  a_hold_owner: assert property (hold_request == !video_owns_memory)
    else $error("hold does not match owner");
  a_write_drive: assert property (write_buffer_enable |-> host_wr && !video_owns_memory)
    else $error("write drivers on outside host write");
  a_oe_on: assert property (!host_select_n [*2] |-> host_rdata_oe)
    else $error("read drivers off while selected");
  a_oe_off: assert property (host_select_n [*2] |-> !host_rdata_oe)
    else $error("read drivers on while not selected");
  a_gate_block: assert property ((!refresh_n || !board_select || !mem_request) |=> host_select_n)
    else $error("host decoded while gated off");
  a_grant_soon: assert property ($fell(host_select_n) |-> ##[1:30] hold_request)
    else $error("host never granted");
  a_host_len: assert property ($rose(ce_any) && !video_owns_memory |-> ce_any [*6] ##1 !ce_any)
    else $error("host cycle length wrong");
  a_video_len: assert property ($rose(ce_any) && video_owns_memory |-> ce_any [*4] ##1 !ce_any)
    else $error("video cycle length wrong");
  a_line_len: assert property (hsync && !hs_q && seen_q |-> gap_q == 10'h2e0)
    else $error("line length wrong");
endmodule : fma_props

bind fma_top fma_props fma_props_i (.pclk, .presetn, .host_wr, .mem_request, .refresh_n,
  .board_select, .host_select_n, .host_rdata_oe, .hold_request, .even_bank_enable,
  .odd_bank_enable, .write_buffer_enable, .video_owns_memory, .hsync);

/* test/fma_host_model.sv */
// Purpose: Host processor memory bus model
// Assumes: access is called just after a pclk edge
// Notes: Released address and data show inverted values; refresh_n and board_select idle high
`timescale 1ns/1ps
module fma_host_model (
  // Clock
  input wire logic pclk,
  // From the device
  input wire logic [7:0] host_rdata,
  input wire logic hold_request,
  // To the device
  output logic [15:0] host_addr,
  output logic [7:0] host_wdata,
  output logic host_wr,
  output logic mem_request,
  output logic refresh_n,
  output logic rom_select,
  output logic board_select
);
  // Idle bus, pulled-up lines high
  initial begin
    host_addr = 16'hffff;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    mem_request = 1'b0;
    refresh_n = 1'b1;
    rom_select = 1'b0;
    board_select = 1'b1;
  end
  // One byte cycle; ctl is rom, refresh_n, board_select; got is low if never granted
  task access(input logic wr, input logic [15:0] a, input logic [7:0] wd,
      input logic [2:0] ctl, output logic [7:0] rd, output logic got);
    int n;
    host_addr <= a;
    host_wdata <= wd;
    host_wr <= wr;
    board_select <= ctl[0];
    refresh_n <= ctl[1];
    rom_select <= ctl[2];
    mem_request <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!hold_request && n < 40);
    got = hold_request;
    // Hold everything until the device lets go
    while (hold_request && n < 80) begin
      @(posedge pclk);
      n++;
    end
    rd = host_rdata;
    host_addr <= ~a;
    host_wdata <= ~wd;
    host_wr <= 1'b0;
    mem_request <= 1'b0;
    board_select <= 1'b1;
    refresh_n <= 1'b1;
    rom_select <= 1'b0;
    @(posedge pclk);
  endtask : access
endmodule : fma_host_model

/* test/fma_top_bench.sv */
// Purpose: Self-checking bench for fma_top
// Assumes: 10 MHz pclk, host model on the memory bus
// Notes: One task per scenario
`timescale 1ns/1ps
module fma_top_bench;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd32;
  logic [15:0] host_addr;
  logic [7:0] host_wdata, host_rdata, rd8;
  logic host_wr, mem_request, refresh_n, rom_select, board_select, err, got;
  logic host_rdata_oe, hold_request, host_select_n, even_bank_enable, odd_bank_enable;
  logic write_buffer_enable, video_owns_memory, video_pixel, hsync, vsync;
  int failures, checks_done, cycles;
  fma_top fma_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .host_addr, .host_wdata, .host_wr, .mem_request, .refresh_n,
    .rom_select, .board_select, .host_rdata, .host_rdata_oe, .hold_request, .host_select_n,
    .even_bank_enable, .odd_bank_enable, .write_buffer_enable, .video_owns_memory,
    .video_pixel, .hsync, .vsync);
  fma_host_model fma_host_model_i (.pclk, .host_rdata, .hold_request, .host_addr,
    .host_wdata, .host_wr, .mem_request, .refresh_n, .rom_select, .board_select);
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      close_out();
    end
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task close_out();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task cmp_val(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp_val
  // APB transfer: setup, then access until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    rd32 = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task host(input logic w, input logic [15:0] a, input logic [7:0] wd, input logic [2:0] c);
    fma_host_model_i.access(w, a, wd, c, rd8, got);
  endtask : host
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset();
    cmp_val(video_owns_memory, 32'h1);
    cmp_val({hold_request, even_bank_enable, odd_bank_enable, host_select_n}, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    cmp_val(rd32, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    cmp_val({err, rd32[30:0]}, 32'h8000_0000);
    $display("test reset done");
  endtask : t_reset
  task t_store();
    logic [15:0] a [4];
    logic [7:0] d [4];
    a = '{16'h0000, 16'h0001, 16'h1ffe, 16'h1fff};
    d = '{8'ha5, 8'h3c, 8'h81, 8'h7e};
    for (int i = 0; i < 4; i++) begin
      host(1'b1, a[i], d[i], 3'h3);
      cmp_val(got, 32'h1);
    end
    for (int i = 0; i < 4; i++) begin
      host(1'b0, a[i], 8'h00, 3'h3);
      cmp_val(rd8, d[i]);
    end
    $display("test store done");
  endtask : t_store
  task t_fill();
    apb(1'b1, 12'h000, 32'h0);
    host(1'b0, 16'h0001, 8'h00, 3'h3);
    cmp_val(rd8, 8'hff);
    host(1'b1, 16'h0002, 8'h5a, 3'h3);
    apb(1'b1, 12'h000, 32'h1);
    host(1'b0, 16'h0002, 8'h00, 3'h3);
    cmp_val(rd8, 8'h5a);
    $display("test fill done");
  endtask : t_fill
  task t_refuse();
    logic [15:0] a [4];
    logic [2:0] c [4];
    a = '{16'h0000, 16'h0000, 16'h2000, 16'h0000};
    c = '{3'h2, 3'h1, 3'h3, 3'h7};
    apb(1'b1, 12'h000, 32'h11);
    for (int i = 0; i < 4; i++) begin
      host(1'b1, a[i], 8'hee, c[i]);
      cmp_val(got, 32'h0);
    end
    apb(1'b1, 12'h000, 32'h3);
    host(1'b0, 16'h2000, 8'h00, 3'h3);
    cmp_val({got, rd8}, 32'h1a5);
    apb(1'b1, 12'h000, 32'h1);
    $display("test refuse done");
  endtask : t_refuse
  task t_pixel();
    logic [8:0] t;
    logic [7:0] px;
    apb(1'b0, 12'h004, 32'h0);
    cmp_val(rd32[25:24], 32'h1);
    t = rd32[8:0] + 9'h002;
    host(1'b1, {3'h0, t[7:0], 5'h00}, 8'hb4, 3'h3);
    cmp_val(vsync, 32'h0);
    do apb(1'b0, 12'h004, 32'h0); while (rd32[8:0] != t);
    while (hsync) @(posedge pclk);
    repeat (80) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      px[7 - i] = video_pixel;
      repeat (2) @(posedge pclk);
    end
    cmp_val(px, 32'hb4);
    $display("test pixel done");
  endtask : t_pixel
  task t_raster();
    int n;
    n = 0;
    while (hsync) @(posedge pclk);
    while (!hsync) @(posedge pclk);
    while (hsync) begin
      @(posedge pclk);
      n++;
    end
    cmp_val(n, 32'd48);
    while (!hsync) begin
      @(posedge pclk);
      n++;
    end
    cmp_val(n, 32'd736);
    $display("test raster done");
  endtask : t_raster
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'b0;
    failures = 0;
    checks_done = 0;
    cycles = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_store();
    t_fill();
    t_refuse();
    t_pixel();
    t_raster();
    close_out();
  end
endmodule : fma_top_bench
